//--- src/sink_status_output_control.sv
// Purpose: output pin control of a standalone usb pd sink controller
// Assumes: events are one-cycle pulses from logic on this clock; open-drain enables low = driving low
// Notes: configuration fields are caught once after reset release
//
// Summary of operation
// - in contract config 2 the output for the negotiated profile goes low when ps_ready arrives.
// - in contract config 2, on a source-initiated renegotiation the active contract output is released when the request is sent.
// - on detach in contract config 2 the contract outputs keep their state while the power path enable is released.
// - both contract outputs are released after rst, but not after a hard reset or error recovery, and in contract config 2 after a new attach.
// - gpio function 00b drives the general output low while bit 0 of register 2Dh is set.
// - gpio function 01b drives the general output low while a hardware fault is detected.
// - gpio function 10b drives the general output low while a debug accessory is detected.
// - gpio function 11b drives the general output low for a 3.0 A advertisement only.
// - with high-voltage-only clear the power path enable is low whenever a source is attached.
// - with high-voltage-only set the power path enable is low only when attached with a profile 2 or 3 contract.
// - orientation output is released for cc1 active and driven low for cc2 active while attached.
// - discharge starts on detach, lower voltage, hard reset and error recovery for the configured time.
// - contract config selects unused, profile 2/3 contract, or 3.0 A/1.5 A advertisement.
`timescale 1ns/100ps
module sink_status_output_control #(
  parameter int unit_cycles = sink_out_pkg::discharge_out_unit_cycles
) (
  input wire logic clock,
  input wire logic rst,
  input wire sink_out_pkg::nvm_cfg_t nvm_cfg,
  input wire sink_out_pkg::pd_event_t pd_event,
  input wire sink_out_pkg::cc_status_t cc_status,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output sink_out_pkg::pins_t pins
);
  sink_out_pkg::nvm_cfg_t cfg_ff;
  logic cfg_loaded_ff;
  logic [7:0] gpio_sw_ff;
  logic [7:0] rdata_ff;
  logic attached_ff;
  logic [1:0] contract_ff;
  logic ok_a_ff;
  logic ok_b_ff;
  logic discharge_out_start;
  logic discharge_out_active;
  logic gpio_low;
  logic path_low;
  logic adv_a;
  logic adv_b;

  initial begin
    if (unit_cycles < 1) begin
      $error("sink_status_output_control: unit_cycles must be at least one");
    end
  end

  // latch once after reset so later nvm changes cannot glitch outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_loaded_ff <= 1'b0;
      cfg_ff.gpio_function <= sink_out_pkg::cfg_gpio_reset;
      cfg_ff.contract_output_config <= sink_out_pkg::cfg_ok_reset;
      cfg_ff.high_voltage_only_power <= 1'b0;
      cfg_ff.discharge_time <= '0;
    end else if (!cfg_loaded_ff) begin
      cfg_loaded_ff <= 1'b1;
      cfg_ff <= nvm_cfg;
    end
  end

  // software register at 2Dh
  always_ff @(posedge clock) begin
    if (rst) begin
      gpio_sw_ff <= sink_out_pkg::gpio_sw_reset;
    end else if (reg_write && reg_addr == sink_out_pkg::gpio_sw_addr) begin
      gpio_sw_ff <= reg_wdata;
    end
  end

  // unmapped addresses read zero
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (reg_read) begin
      rdata_ff <= (reg_addr == sink_out_pkg::gpio_sw_addr) ? gpio_sw_ff : 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      attached_ff <= 1'b0;
    end else if (pd_event.attach) begin
      attached_ff <= 1'b1;
    end else if (pd_event.detach) begin
      attached_ff <= 1'b0;
    end
  end

  // negotiated contract; detach leaves it so contract outputs stay asserted
  always_ff @(posedge clock) begin
    if (rst) begin
      contract_ff <= sink_out_pkg::prof_none;
    end else if (pd_event.attach) begin
      contract_ff <= sink_out_pkg::prof_none;
    end else if (pd_event.request_sent) begin
      contract_ff <= sink_out_pkg::prof_none;
    end else if (pd_event.ps_ready) begin
      contract_ff <= pd_event.request_profile;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ok_a_ff <= 1'b0;
      ok_b_ff <= 1'b0;
    end else begin
      case (cfg_ff.contract_output_config)
        sink_out_pkg::ok_cfg_contract: begin
          ok_a_ff <= contract_ff == sink_out_pkg::prof_2;
          ok_b_ff <= contract_ff == sink_out_pkg::prof_3;
        end
        sink_out_pkg::ok_cfg_current: begin
          ok_a_ff <= adv_a;
          ok_b_ff <= adv_b;
        end
        default: begin
          ok_a_ff <= 1'b0;
          ok_b_ff <= 1'b0;
        end
      endcase
    end
  end

  assign adv_a = attached_ff && cc_status.advertised_current == sink_out_pkg::adv_3a0;
  assign adv_b = attached_ff && cc_status.advertised_current == sink_out_pkg::adv_1a5;

  always_comb begin
    case (cfg_ff.gpio_function)
      sink_out_pkg::gpio_fn_software: gpio_low = gpio_sw_ff[sink_out_pkg::gpio_sw_bit];
      sink_out_pkg::gpio_fn_fault: gpio_low = cc_status.hw_fault;
      sink_out_pkg::gpio_fn_debug: gpio_low = cc_status.debug_accessory;
      sink_out_pkg::gpio_fn_current: gpio_low = cc_status.advertised_current == sink_out_pkg::adv_3a0;
      default: gpio_low = 1'b0;
    endcase
  end

  // power path follows attach, optionally gated by a high-voltage contract
  assign path_low = attached_ff && (!cfg_ff.high_voltage_only_power
    || contract_ff == sink_out_pkg::prof_2 || contract_ff == sink_out_pkg::prof_3);

  assign discharge_out_start = pd_event.detach || pd_event.lower_voltage
    || pd_event.hard_reset || pd_event.error_recovery;

  discharge_timer #(
    .unit_cycles(unit_cycles),
    .time_width(4)
  ) u_discharge (
    .clock(clock),
    .rst(rst),
    .start(discharge_out_start),
    .duration(cfg_ff.discharge_time),
    .active(discharge_out_active)
  );

  // registered pin enables keep outputs glitch free
  always_ff @(posedge clock) begin
    if (rst) begin
      pins <= '1;
      pins.bus_sense_discharge <= 1'b0;
    end else begin
      pins.contract_out_a_oe_n <= !ok_a_ff;
      pins.contract_out_b_oe_n <= !ok_b_ff;
      pins.power_path_enable_n_oe_n <= !path_low;
      pins.software_driven_output_oe_n <= !gpio_low;
      pins.orientation_oe_n <= !(attached_ff && cc_status.cc2_active);
      pins.discharge_out_oe_n <= !discharge_out_active;
      pins.bus_sense_discharge <= discharge_out_active;
    end
  end

  assign reg_rdata = rdata_ff;
endmodule : sink_status_output_control

//--- common/sink_out_pkg.sv
// Purpose: shared constants and carriers for the sink status output block
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: open-drain outputs carry a low-active output enable
package sink_out_pkg;
  localparam logic [7:0] gpio_sw_addr = 8'h2D;
  localparam logic [7:0] gpio_sw_reset = 8'h00;
  localparam int gpio_sw_bit = 0;
  localparam logic [1:0] gpio_fn_software = 2'h0;
  localparam logic [1:0] gpio_fn_fault = 2'h1;
  localparam logic [1:0] gpio_fn_debug = 2'h2;
  localparam logic [1:0] gpio_fn_current = 2'h3;
  localparam logic [1:0] ok_cfg_unused = 2'h0;
  localparam logic [1:0] ok_cfg_na = 2'h1;
  localparam logic [1:0] ok_cfg_contract = 2'h2;
  localparam logic [1:0] ok_cfg_current = 2'h3;
  localparam logic [1:0] cfg_gpio_reset = 2'h1;
  localparam logic [1:0] cfg_ok_reset = 2'h2;
  localparam int clk_mhz = 100;
  localparam int discharge_out_unit_us = 84;
  localparam int discharge_out_unit_cycles = discharge_out_unit_us * clk_mhz;
  localparam logic [1:0] prof_none = 2'h0;
  localparam logic [1:0] prof_1 = 2'h1;
  localparam logic [1:0] prof_2 = 2'h2;
  localparam logic [1:0] prof_3 = 2'h3;
  localparam logic [1:0] adv_default = 2'h0;
  localparam logic [1:0] adv_1a5 = 2'h1;
  localparam logic [1:0] adv_3a0 = 2'h2;

  typedef struct packed {
    logic [1:0] gpio_function;
    logic [1:0] contract_output_config;
    logic high_voltage_only_power;
    logic [3:0] discharge_time;
  } nvm_cfg_t;

  typedef struct packed {
    logic attach;
    logic detach;
    logic ps_ready;
    logic request_sent;
    logic [1:0] request_profile;
    logic lower_voltage;
    logic hard_reset;
    logic error_recovery;
  } pd_event_t;

  typedef struct packed {
    logic hw_fault;
    logic debug_accessory;
    logic [1:0] advertised_current;
    logic cc2_active;
  } cc_status_t;

  typedef struct packed {
    logic contract_out_a_oe_n;
    logic contract_out_b_oe_n;
    logic power_path_enable_n_oe_n;
    logic software_driven_output_oe_n;
    logic orientation_oe_n;
    logic discharge_out_oe_n;
    logic bus_sense_discharge;
  } pins_t;
endpackage : sink_out_pkg

//--- src/discharge_timer.sv
// Purpose: holds bus discharge active for a configured number of time units
// Assumes: start is a one-cycle pulse on the same clock
// Notes: a new start restarts the full duration
`timescale 1ns/100ps
module discharge_timer #(
  parameter int unit_cycles = sink_out_pkg::discharge_out_unit_cycles,
  parameter int time_width = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic [time_width-1:0] duration,
  output logic active
);
  localparam int unit_width = $clog2(unit_cycles + 1);

  logic [unit_width-1:0] unit_ff;
  logic [time_width-1:0] left_ff;
  logic active_ff;

  initial begin
    if (unit_cycles < 1) begin
      $error("discharge_timer: unit_cycles must be at least one");
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      active_ff <= 1'b0;
      unit_ff <= '0;
      left_ff <= '0;
    end else if (start) begin
      // zero duration still gives one unit so discharge is never skipped
      active_ff <= 1'b1;
      unit_ff <= unit_width'(unit_cycles - 1);
      left_ff <= duration;
    end else if (active_ff) begin
      if (unit_ff != '0) begin
        unit_ff <= unit_ff - 1'b1;
      end else if (left_ff > 1) begin
        left_ff <= left_ff - 1'b1;
        unit_ff <= unit_width'(unit_cycles - 1);
      end else begin
        active_ff <= 1'b0;
      end
    end
  end

  assign active = active_ff;
endmodule : discharge_timer

//--- verif/pd_source_model.sv
// Purpose: source side model raising pd events and cc levels
// Assumes: events launched at the falling edge
// Notes: cc_status is set by the bench between events
`timescale 1ns/100ps
module pd_source_model (
  input wire logic clock,
  output sink_out_pkg::pd_event_t pd_event,
  output sink_out_pkg::cc_status_t cc_status
);
  initial begin
    pd_event = '0;
    cc_status = '0;
  end
  // one-cycle pulse, never two events in one edge
  task automatic send(input sink_out_pkg::pd_event_t ev);
    @(negedge clock);
    pd_event = ev;
    @(negedge clock);
    pd_event = '0;
  endtask : send
endmodule : pd_source_model

//--- verif/sink_status_output_control_chk.sv
// Purpose: pin timing checks
// Assumes: nvm_cfg steady between resets
// Notes: contract pins lag their event by up to 3 cycles
`timescale 1ns/100ps
module sink_status_output_control_chk #(
  parameter int unit_cycles = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire sink_out_pkg::nvm_cfg_t nvm_cfg,
  input wire sink_out_pkg::pd_event_t pd_event,
  input wire sink_out_pkg::cc_status_t cc_status,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire sink_out_pkg::pins_t pins
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire logic cfg2 = nvm_cfg.contract_output_config == 2'h2;
  wire logic both_off = pins.contract_out_a_oe_n && pins.contract_out_b_oe_n;
  wire logic quiet = !pd_event.attach && !pd_event.request_sent;
  sequence fault_held;
    cc_status.hw_fault [*3];
  endsequence
  sequence fault_mode_held;
    (nvm_cfg.gpio_function == 2'h1) [*3];
  endsequence
  ready_low_a:
    assert property (pd_event.ps_ready && pd_event.request_profile == 2'h2 && quiet && cfg2
      |-> ##[2:3] !pins.contract_out_a_oe_n) else $error("contract a not driven");
  request_release_a:
    assert property (pd_event.request_sent && !pd_event.attach |-> ##[2:3] both_off) else $error("not released");
  attach_release_a:
    assert property (pd_event.attach && cfg2 |-> ##[2:3] both_off) else $error("attach kept contract");
  detach_power_a:
    assert property (pd_event.detach && !pd_event.attach |-> ##[1:2] pins.power_path_enable_n_oe_n)
      else $error("power path kept");
  discharge_on_a:
    assert property ((pd_event.detach || pd_event.lower_voltage || pd_event.hard_reset
      || pd_event.error_recovery) |-> ##[1:2]
      (pins.bus_sense_discharge && !pins.discharge_out_oe_n)) else $error("no discharge");
  sw_drive_a:
    assert property (reg_write && reg_addr == 8'h2D && reg_wdata[0] && nvm_cfg.gpio_function == 2'h0
      |-> ##2 !pins.software_driven_output_oe_n) else $error("sw output idle");
  fault_drive_a:
    assert property ((fault_mode_held and fault_held) |-> !pins.software_driven_output_oe_n)
      else $error("fault not shown");
  hv_contract_a:
    assert property (nvm_cfg.high_voltage_only_power && cfg2 && $fell(pins.power_path_enable_n_oe_n)
      |-> ##[0:2] !both_off) else $error("power without contract");
  refused_read_a:
    assert property (reg_read && reg_addr != 8'h2D |=> reg_rdata == 8'h00) else $error("unmapped read");
endmodule : sink_status_output_control_chk
bind sink_status_output_control sink_status_output_control_chk #(.unit_cycles(unit_cycles)) chk_i (
  .clock(clock), .rst(rst), .nvm_cfg(nvm_cfg), .pd_event(pd_event), .cc_status(cc_status),
  .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .pins(pins));

//--- verif/sink_status_output_control_test.sv
// Purpose: directed checks of the sink status outputs
// Assumes: discharge unit cut to 4 cycles
// Notes: each reset boots a new configuration
`timescale 1ns/100ps
module sink_status_output_control_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  sink_out_pkg::nvm_cfg_t nvm_cfg = 9'h041;
  sink_out_pkg::pd_event_t pd_event;
  sink_out_pkg::cc_status_t cc_status;
  sink_out_pkg::pins_t pins;
  logic [8:0] dis [3] = '{9'h004, 9'h002, 9'h001};
  int error_cnt = 0;
  int num_checks = 0;
  always #5 clock = ~clock;
  pd_source_model src (.clock(clock), .pd_event(pd_event), .cc_status(cc_status));
  sink_status_output_control #(.unit_cycles(4)) dut (.clock(clock), .rst(rst), .nvm_cfg(nvm_cfg),
    .pd_event(pd_event), .cc_status(cc_status), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pins(pins));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_write = wr;
    reg_read = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_write = 1'b0;
    reg_read = 1'b0;
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    @(negedge clock);
    chk(reg_rdata, exp);
  endtask : rd
  // contract pins settle three edges after the event
  task automatic ev(input logic [8:0] e, input logic [6:0] exp);
    if (e != 9'h000) src.send(e);
    repeat (3) @(negedge clock);
    chk({1'b0, pins}, {1'b0, exp});
  endtask : ev
  task automatic boot(input logic [8:0] cfg);
    @(negedge clock);
    rst = 1'b1;
    nvm_cfg = cfg;
    src.cc_status = 5'h00;
    repeat (2) @(negedge clock);
    rst = 1'b0;
  endtask : boot
  initial begin
    boot(9'h041);
    ev(9'h000, 7'h7E);
    rd(8'h2D, 8'h00);
    ev(9'h100, 7'h6E);
    acc(1'b1, 8'h2D, 8'h01);
    acc(1'b1, 8'h2C, 8'hFF);
    rd(8'h2D, 8'h01);
    rd(8'h2C, 8'h00);
    ev(9'h000, 7'h66);
    ev(9'h050, 7'h26);
    ev(9'h020, 7'h66);
    ev(9'h058, 7'h46);
    src.cc_status = 5'h01;
    ev(9'h000, 7'h42);
    ev(9'h080, 7'h55);
    repeat (6) @(negedge clock);
    ev(9'h000, 7'h56);
    ev(9'h100, 7'h62);
    foreach (dis[i]) begin
      src.send(dis[i]);
      repeat (2) @(negedge clock);
      chk({6'h00, pins.discharge_out_oe_n, pins.bus_sense_discharge}, 8'h01);
      repeat (8) @(negedge clock);
    end
    boot(9'h0F1);
    src.cc_status = 5'h04;
    ev(9'h100, 7'h3E);
    src.cc_status = 5'h02;
    ev(9'h000, 7'h5E);
    src.cc_status = 5'h12;
    ev(9'h000, 7'h56);
    ev(9'h050, 7'h46);
    boot(9'h101);
    src.cc_status = 5'h08;
    ev(9'h100, 7'h66);
    ev(9'h050, 7'h66);
    boot(9'h1D1);
    src.cc_status = 5'h04;
    ev(9'h100, 7'h76);
    ev(9'h048, 7'h76);
    ev(9'h050, 7'h26);
    nvm_cfg = 9'h000;
    ev(9'h000, 7'h26);
    finish_test();
  end
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
endmodule : sink_status_output_control_test
